// file: src/ftc_pkg.sv
// Constants, field layout and carrier types for the fast timer/counter core.
// Assumes a byte-wide register port on the system clock and a 20 MHz system clock.
// Operation
// - Count, high bits and flags read back through a delaying synchroniser.
// - Bottom is signalled when the count becomes zero.
// - Eight-bit maximum is 255 and is signalled on reaching it.
// - Top is either the fixed maximum or the top compare register.
// - Tick source is system clock, or fast clock when async enable is one.
// - Prescaler offers undivided through divide by 16384, plus stop.
// - Fast clock is 64 MHz, or 32 MHz with low speed select.
// - Writing one to prescaler reset clears the prescaler.
// - Each tick clears, increments or decrements the count per mode.
// - Clock select zero stops counting; count stays readable and writable.
// - CPU write to count beats any simultaneous clear or count.
// - Mode fields shape the sequence; overflow flag set where mode says.
// - Count compared continuously against all four compare registers.
// - Match sets its flag on the following tick; enabled flag requests.
// - Flag clears on interrupt service or on software writing one.
// - PWM modes buffer compare writes until top or bottom; normal bypasses.
// - Compare reads return the buffered, most recently written value.
// - Force compare in non-PWM modes drives output, no flag, no reload.
// - Count write blocks all matches in the next tick, even stopped.
// - Low byte read copies upper bits to buffer; write takes them.
// - Third compare register holds the clear-at value, drives no waveform output.
package ftc_pkg;
    localparam int CNT_W  = 10;
    localparam int PRE_W  = 14;
    localparam int ADDR_W = 4;

    // Register offsets
    localparam logic [3:0] ADDR_CTRL_A = 4'h0;
    localparam logic [3:0] ADDR_CTRL_B = 4'h1;
    localparam logic [3:0] ADDR_CTRL_C = 4'h2;
    localparam logic [3:0] ADDR_CTRL_D = 4'h3;
    localparam logic [3:0] ADDR_PLL    = 4'h4;
    localparam logic [3:0] ADDR_COUNT  = 4'h5;
    localparam logic [3:0] ADDR_HIGH   = 4'h6;
    localparam logic [3:0] ADDR_CMP_A  = 4'h7;
    localparam logic [3:0] ADDR_CMP_B  = 4'h8;
    localparam logic [3:0] ADDR_CMP_T  = 4'h9;
    localparam logic [3:0] ADDR_CMP_D  = 4'hA;
    localparam logic [3:0] ADDR_FLAGS  = 4'hB;
    localparam logic [3:0] ADDR_MASK   = 4'hC;

    // Field positions
    localparam int CA_PWM_A  = 0;
    localparam int CA_PWM_B  = 1;
    localparam int CA_FORCE_A = 2;
    localparam int CA_FORCE_B = 3;
    localparam int CA_ACT_A  = 4;
    localparam int CA_ACT_B  = 6;
    localparam int CB_PSR    = 7;
    localparam int CC_PWM_D  = 0;
    localparam int CC_FORCE_D = 1;
    localparam int CC_ACT_D  = 2;
    localparam int PL_ASYNC  = 0;
    localparam int PL_LSM    = 1;
    localparam int PL_PLLEN  = 2;
    localparam int PL_LOCK   = 3;

    // Flag bits: compare units 0,1,3 plus overflow in slot 2 (top unit has no flag)
    localparam int FLAG_OVF = 2;

    localparam logic [7:0]       RST_BYTE  = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ZERO  = 10'h000;
    localparam logic [CNT_W-1:0] CNT_MAX   = 10'h0FF;
    localparam logic [CNT_W-1:0] CMP_RESET = 10'h0FF;
    localparam logic [1:0]       MODE_MAX_TOP = 2'h3;
    localparam logic [1:0]       MODE_UPDOWN  = 2'h1;

    // Output action codes
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR  = 2'h2;
    localparam logic [1:0] ACT_SET    = 2'h3;

    // Fast clock rates, for reference by the PLL side
    localparam int FAST_MHZ      = 64;
    localparam int FAST_LSM_MHZ  = 32;

    typedef struct packed {
        logic             valid;
        logic [CNT_W-1:0] value;
    } ftc_cnt_wr_s;

    typedef struct packed {
        logic [3:0]       flags;
        logic [CNT_W-1:0] count;
    } ftc_status_s;
endpackage : ftc_pkg

// file: src/ftc_core.sv
// Fast timer/counter: prescaler, up/down counter, four compare units.
// Assumes one system clock; the fast peripheral clock arrives as a pin
// whose edges are sampled, so it must be slower than half the system clock here.
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ftc_core
    import ftc_pkg::*;
#(
    parameter int CW = CNT_W,
    parameter int PW = PRE_W
) (
    // Clock and reset
    input  wire logic              clock_in,
    input  wire logic              rst_in,
    // Register port
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [7:0]        wdata_in,
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    output logic      [7:0]        rdata_out,
    // Fast peripheral clock and PLL
    input  wire logic              fast_clk_in,
    input  wire logic              pll_locked_in,
    output logic                   pll_enable_out,
    output logic                   low_speed_select_out,
    // Interrupt service
    input  wire logic [3:0]        service_ack_in,
    output logic      [3:0]        irq_out,
    // Waveform outputs a, b, d
    output logic      [2:0]        waveform_output_out,
    output logic                   top_out,
    output logic                   bottom_out
);

    // Register layout fixes both widths
    if (CW != CNT_W || PW != PRE_W) begin : g_width_check
        $error("ftc_core: widths must match the register layout");
    end

    // Software state
    logic [7:0]    ctrl_a_q, ctrl_c_q, pll_q, mask_q;
    logic [3:0]    clock_select_q;
    logic [1:0]    waveform_mode_q;
    logic [1:0]    high_bits_buffer_q;
    logic [3:0]    flags_q;
    logic [CW-1:0] count_q;
    logic          dir_down_q;
    logic          block_q;
    logic [3:0]    arm_q;
    logic [2:0]    wave_q;
    logic [PW-1:0] presc_q;
    logic [2:0]    fast_sync_q;
    logic [1:0]    lock_sync_q;
    logic          psr_q;
    logic [7:0]    rdata_q;
    logic [3:0]    irq_q;
    logic          top_q, bottom_q;
    logic [CW-1:0] cmp_buf_q [4];
    logic [CW-1:0] cmp_act_q [4];

    // Cross-domain stages
    ftc_cnt_wr_s   cnt_wr_s1_q, cnt_wr_s2_q;
    logic [3:0]    clr_s1_q, clr_s2_q;
    ftc_status_s   stat_s1_q, stat_s2_q;

    // Register decode
    wire wr_ctrl_a = wr_in && addr_in == ADDR_CTRL_A;
    wire wr_ctrl_b = wr_in && addr_in == ADDR_CTRL_B;
    wire wr_ctrl_c = wr_in && addr_in == ADDR_CTRL_C;
    wire wr_ctrl_d = wr_in && addr_in == ADDR_CTRL_D;
    wire wr_pll    = wr_in && addr_in == ADDR_PLL;
    wire wr_count  = wr_in && addr_in == ADDR_COUNT;
    wire wr_high   = wr_in && addr_in == ADDR_HIGH;
    wire wr_flags  = wr_in && addr_in == ADDR_FLAGS;
    wire wr_mask   = wr_in && addr_in == ADDR_MASK;

    function automatic logic [2:0] cmp_index(input logic [ADDR_W-1:0] a);
        logic [2:0] r;
        r = 3'h4;
        if (a == ADDR_CMP_A) r = 3'h0;
        else if (a == ADDR_CMP_B) r = 3'h1;
        else if (a == ADDR_CMP_T) r = 3'h2;
        else if (a == ADDR_CMP_D) r = 3'h3;
        return r;
    endfunction : cmp_index

    wire [2:0] cmp_sel     = cmp_index(addr_in);
    wire       cmp_hit     = !cmp_sel[2];
    wire [1:0] cmp_idx     = cmp_sel[1:0];
    wire [CW-1:0] wr_value = {high_bits_buffer_q, wdata_in};

    // Mode decode
    wire async_mode = pll_q[PL_ASYNC];
    wire pwm_mode   = ctrl_a_q[CA_PWM_A] | ctrl_a_q[CA_PWM_B] | ctrl_c_q[CC_PWM_D];
    wire updown     = pwm_mode && waveform_mode_q == MODE_UPDOWN;
    wire [CW-1:0] top_val = (waveform_mode_q == MODE_MAX_TOP) ? CNT_MAX
                                                              : cmp_act_q[2];
    wire [1:0] act [3];
    assign act[0] = ctrl_a_q[CA_ACT_A +: 2];
    assign act[1] = ctrl_a_q[CA_ACT_B +: 2];
    assign act[2] = ctrl_c_q[CC_ACT_D +: 2];

    // Prescaler; edge of the fast clock taken only after two flops
    wire fast_edge = fast_sync_q[1] & ~fast_sync_q[2];
    wire src_en    = async_mode ? fast_edge : 1'b1;
    wire [PW-1:0] presc_mask = (clock_select_q == 4'h0) ? '0
                             : PW'((1 << (clock_select_q - 4'h1)) - 1);
    wire tick = src_en && clock_select_q != 4'h0
                && (presc_q & presc_mask) == presc_mask;

    // Counter next value
    wire at_top    = count_q == top_val;
    wire at_bottom = count_q == CNT_ZERO;
    wire at_max    = count_q == CNT_MAX;
    wire [CW-1:0] cnt_up   = count_q + CW'(1);
    wire [CW-1:0] cnt_down = count_q - CW'(1);
    wire going_down = updown && (dir_down_q || at_top) && !(dir_down_q && at_bottom);
    wire [CW-1:0] cnt_next = updown ? (going_down ? cnt_down : cnt_up)
                                    : (at_top ? CNT_ZERO : cnt_up);
    wire ovf_event = tick && (updown ? (dir_down_q && cnt_down == CNT_ZERO)
                                     : at_top);
    wire upd_point = updown ? at_bottom : at_top;

    // Synchronised count write and flag clears
    wire cnt_apply = cnt_wr_s2_q.valid;

    wire [3:0] cmp_eq;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_cmp
            assign cmp_eq[gi] = count_q == cmp_act_q[gi];

            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    cmp_buf_q[gi] <= CMP_RESET;
                end else if (wr_in && cmp_hit && cmp_idx == 2'(gi)) begin
                    cmp_buf_q[gi] <= wr_value;
                end
            end

            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    cmp_act_q[gi] <= CMP_RESET;
                end else if (!pwm_mode || (tick && upd_point)) begin
                    cmp_act_q[gi] <= cmp_buf_q[gi];
                end
            end
        end

        for (gi = 0; gi < 3; gi++) begin : g_wave
            localparam int U = (gi == 2) ? 3 : gi;
            wire force_bit = (gi == 0) ? ctrl_a_q[CA_FORCE_A]
                           : (gi == 1) ? ctrl_a_q[CA_FORCE_B] : ctrl_c_q[CC_FORCE_D];
            wire real_match = tick && arm_q[U];
            wire hit = real_match || (force_bit && !pwm_mode);
            logic nxt;
            always_comb begin
                nxt = wave_q[gi];
                if (pwm_mode) begin
                    if (act[gi] != ACT_NONE && tick && upd_point && !updown)
                        nxt = act[gi] != ACT_SET;
                    if (act[gi] != ACT_NONE && real_match)
                        nxt = act[gi] == ACT_SET;
                end else if (hit) begin
                    case (act[gi])
                        ACT_TOGGLE: nxt = ~wave_q[gi];
                        ACT_CLEAR:  nxt = 1'b0;
                        ACT_SET:    nxt = 1'b1;
                        default:    nxt = wave_q[gi];
                    endcase
                end
            end

            // Force only outside PWM
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    wave_q[gi] <= 1'b0;
                end else begin
                    wave_q[gi] <= nxt;
                end
            end
        end
    endgenerate

    // Flags: hardware set wins over any clear in the same cycle
    wire [3:0] flag_set = {tick && arm_q[3], ovf_event,
                           tick && arm_q[1], tick && arm_q[0]};
    wire [3:0] flag_clr = clr_s2_q | service_ack_in;

    // Read mux
    // Status reads lag two cycles
    logic [7:0] rd_mux;
    wire [CW-1:0] cmp_rd = cmp_buf_q[cmp_idx];
    always_comb begin
        rd_mux = RST_BYTE;
        if (addr_in == ADDR_CTRL_A) rd_mux = ctrl_a_q;
        else if (addr_in == ADDR_CTRL_B) rd_mux = {1'b0, 3'h0, clock_select_q};
        else if (addr_in == ADDR_CTRL_C) rd_mux = ctrl_c_q;
        else if (addr_in == ADDR_CTRL_D) rd_mux = {6'h00, waveform_mode_q};
        else if (addr_in == ADDR_PLL) rd_mux = {4'h0, lock_sync_q[1], pll_q[2:0]};
        else if (addr_in == ADDR_COUNT) rd_mux = stat_s2_q.count[7:0];
        else if (addr_in == ADDR_HIGH) rd_mux = {6'h00, high_bits_buffer_q};
        else if (cmp_hit) rd_mux = cmp_rd[7:0];
        else if (addr_in == ADDR_FLAGS) rd_mux = {4'h0, stat_s2_q.flags};
        else if (addr_in == ADDR_MASK) rd_mux = {4'h0, mask_q[3:0]};
    end

    wire rd_low_count = rd_in && addr_in == ADDR_COUNT;
    wire rd_low_cmp   = rd_in && cmp_hit;

    // Control registers
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ctrl_a_q        <= RST_BYTE;
            ctrl_c_q        <= RST_BYTE;
            clock_select_q  <= 4'h0;
            waveform_mode_q <= 2'h0;
            pll_q           <= RST_BYTE;
            mask_q          <= RST_BYTE;
            psr_q           <= 1'b0;
        end else begin
            // Force bits are strobes
            ctrl_a_q[CA_FORCE_A] <= 1'b0;
            ctrl_a_q[CA_FORCE_B] <= 1'b0;
            ctrl_c_q[CC_FORCE_D] <= 1'b0;

            psr_q                <= wr_ctrl_b && wdata_in[CB_PSR];
            if (wr_ctrl_a) ctrl_a_q <= wdata_in;
            if (wr_ctrl_c) ctrl_c_q <= wdata_in;
            if (wr_ctrl_b) clock_select_q <= wdata_in[3:0];
            if (wr_ctrl_d) waveform_mode_q <= wdata_in[1:0];
            if (wr_pll) pll_q <= {5'h00, wdata_in[2:0]};
            if (wr_mask) mask_q <= wdata_in;
        end
    end

    // High-bits buffer
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            high_bits_buffer_q <= 2'h0;
        end else if (wr_high) begin
            high_bits_buffer_q <= wdata_in[1:0];
        end else if (rd_low_count) begin
            high_bits_buffer_q <= stat_s2_q.count[CW-1:8];
        end else if (rd_low_cmp) begin
            high_bits_buffer_q <= cmp_rd[CW-1:8];
        end
    end

    // Two-stage passage toward the counter and back
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cnt_wr_s1_q <= '0;
            cnt_wr_s2_q <= '0;
            clr_s1_q    <= 4'h0;
            clr_s2_q    <= 4'h0;
            stat_s1_q   <= '0;
            stat_s2_q   <= '0;
            fast_sync_q <= 3'h0;
            lock_sync_q <= 2'h0;
        end else begin
            cnt_wr_s1_q <= '{valid: wr_count, value: wr_value};
            cnt_wr_s2_q <= cnt_wr_s1_q;

            clr_s1_q    <= wr_flags ? wdata_in[3:0] : 4'h0;
            clr_s2_q    <= clr_s1_q;

            stat_s1_q   <= '{flags: flags_q, count: count_q};
            stat_s2_q   <= stat_s1_q;

            fast_sync_q <= {fast_sync_q[1:0], fast_clk_in};
            lock_sync_q <= {lock_sync_q[0], pll_locked_in};
        end
    end

    // Prescaler
    // Held while stopped; reset bit restarts it
    always_ff @(posedge clock_in) begin
        if (rst_in || psr_q) begin
            presc_q <= '0;
        end else if (src_en && clock_select_q != 4'h0) begin
            presc_q <= presc_q + PW'(1);
        end
    end

    // Counter, direction, match blocking and flags
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            count_q    <= CNT_ZERO;
            dir_down_q <= 1'b0;
            block_q    <= 1'b0;
            arm_q      <= 4'h0;
            flags_q    <= 4'h0;
        end else begin
            if (cnt_apply) begin
                count_q <= cnt_wr_s2_q.value;
            end else if (tick) begin
                count_q    <= cnt_next;
                dir_down_q <= going_down;
            end
            if (!updown) dir_down_q <= 1'b0;

            // Held until the next tick
            if (cnt_apply) begin
                block_q <= 1'b1;
            end else if (tick) begin
                block_q <= 1'b0;
            end

            if (tick) begin
                arm_q <= (block_q || cnt_apply) ? 4'h0 : cmp_eq;
            end

            flags_q <= (flags_q & ~flag_clr) | flag_set;
        end
    end

    // Output registers
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rdata_q  <= RST_BYTE;
            irq_q    <= 4'h0;
            top_q    <= 1'b0;
            bottom_q <= 1'b0;
        end else begin
            rdata_q  <= rd_in ? rd_mux : RST_BYTE;
            irq_q    <= flags_q & mask_q[3:0] & ~flag_clr;
            top_q    <= at_top || at_max;
            bottom_q <= at_bottom;
        end
    end

    assign rdata_out            = rdata_q;
    assign irq_out              = irq_q;
    assign waveform_output_out  = wave_q;
    assign pll_enable_out       = pll_q[PL_PLLEN];
    assign low_speed_select_out = pll_q[PL_LSM];
    assign top_out              = top_q;
    assign bottom_out           = bottom_q;

endmodule : ftc_core
`default_nettype wire

// file: verif/ftc_pll_model.sv
// Behavioural PLL feeding the fast peripheral clock and lock status.
// Assumes the core samples the fast clock, so it runs below half the system clock.
`timescale 1ns/1ps
`default_nettype none
module ftc_pll_model #(
    parameter int HALF_NS  = 103,
    parameter int LOCK_CYC = 40
) (
    // System side
    input  wire logic clock_in,
    input  wire logic rst_in,
    // PLL control from the core
    input  wire logic pll_enable_in,
    input  wire logic low_speed_select_in,
    // Clock and lock towards the core
    output logic      fast_clk_out,
    output logic      pll_locked_out
);
    int lock_cnt_q;
    // Scaled down: a true 64 MHz would outrun the core's edge sampling
    always begin
        #((low_speed_select_in === 1'b1) ? 2 * HALF_NS : HALF_NS);
        fast_clk_out = (pll_enable_in === 1'b1) ? ~fast_clk_out : 1'b0;
    end
    always_ff @(posedge clock_in) begin
        if (rst_in || !pll_enable_in) begin
            lock_cnt_q     <= 0;
            pll_locked_out <= 1'b0;
        end else if (lock_cnt_q == LOCK_CYC) begin
            pll_locked_out <= 1'b1;
        end else begin
            lock_cnt_q <= lock_cnt_q + 1;
        end
    end
endmodule : ftc_pll_model
`default_nettype wire

// file: verif/ftc_core_sva.sv
// Assertion checker for the timer core register port and outputs.
// Assumes it is bound to ftc_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ftc_core_sva
    import ftc_pkg::*;
(
    // Clock, reset, register port
    input wire logic              clock_in,
    input wire logic              rst_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [7:0]        wdata_in,
    input wire logic              wr_in,
    input wire logic              rd_in,
    input wire logic [7:0]        rdata_out,
    // PLL and outputs
    input wire logic              pll_locked_in,
    input wire logic              pll_enable_out,
    input wire logic              low_speed_select_out,
    input wire logic [3:0]        irq_out,
    input wire logic [2:0]        waveform_output_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    logic [7:0] cmp_q [4];
    logic       cmp_hit;
    logic [1:0] cmp_idx;
    logic [7:0] cmp_sel;
    logic       force_a_wr;
    assign cmp_hit = (addr_in >= ADDR_CMP_A) && (addr_in <= ADDR_CMP_D);
    assign cmp_idx = 2'(addr_in - ADDR_CMP_A);
    assign cmp_sel = cmp_q[cmp_idx];
    assign force_a_wr = wr_in && addr_in == ADDR_CTRL_A && wdata_in[CA_FORCE_A]
                        && !wdata_in[CA_PWM_A] && !wdata_in[CA_PWM_B];
    // Shadow of the last written compare bytes
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cmp_q <= '{default: CMP_RESET[7:0]};
        end else if (wr_in && cmp_hit) begin
            cmp_q[cmp_idx] <= wdata_in;
        end
    end
    property p_rd_idle;
        !rd_in |=> rdata_out == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unmapped;
        rd_in && addr_in > ADDR_MASK |=> rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_cmp_back;
        rd_in && cmp_hit |=> rdata_out == $past(cmp_sel);
    endproperty
    a_cmp_back: assert property (p_cmp_back) else $error("compare readback wrong");
    property p_pll_en;
        wr_in && addr_in == ADDR_PLL |=> pll_enable_out == $past(wdata_in[PL_PLLEN]);
    endproperty
    a_pll_en: assert property (p_pll_en) else $error("pll enable not taken");
    property p_lsm;
        wr_in && addr_in == ADDR_PLL |=> low_speed_select_out == $past(wdata_in[PL_LSM]);
    endproperty
    a_lsm: assert property (p_lsm) else $error("low speed select not taken");
    property p_lock;
        $stable(pll_locked_in)[*4] ##0 (rd_in && addr_in == ADDR_PLL)
            |=> rdata_out[PL_LOCK] == $past(pll_locked_in);
    endproperty
    a_lock: assert property (p_lock) else $error("lock status wrong");
    property p_mask_off;
        wr_in && addr_in == ADDR_MASK && wdata_in[3:0] == 4'h0 |-> ##[2:3] irq_out == 4'h0;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("masked request still high");
    property p_force_set;
        force_a_wr && wdata_in[CA_ACT_A +: 2] == ACT_SET |-> ##[1:6] waveform_output_out[0];
    endproperty
    a_force_set: assert property (p_force_set) else $error("forced set missing");
    property p_force_clr;
        force_a_wr && wdata_in[CA_ACT_A +: 2] == ACT_CLEAR |-> ##[1:6] !waveform_output_out[0];
    endproperty
    a_force_clr: assert property (p_force_clr) else $error("forced clear missing");
endmodule : ftc_core_sva
bind ftc_core ftc_core_sva u_sva (
    .clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pll_locked_in(pll_locked_in),
    .pll_enable_out(pll_enable_out), .low_speed_select_out(low_speed_select_out),
    .irq_out(irq_out), .waveform_output_out(waveform_output_out)
);
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the fast timer core; read results checked from a queue.
// Assumes the PLL model on the fast clock side and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ftc_pkg::*;
;
    localparam int HALF_NS = 103;
    logic              clock_in = 1'b0;
    logic              rst_in, wr_in, rd_in, fast_clk, pll_locked, pll_en, low_speed_select;
    logic [ADDR_W-1:0] addr_in;
    logic [7:0]        wdata_in, rdata_out, last_rd, v;
    logic [3:0]        service_ack_in, irq_out;
    logic [2:0]        wave;
    logic [7:0]        exp_q[$], msk_q[$];
    logic              rd_d = 1'b0;
    logic [1:0]        acts [4] = '{ACT_SET, ACT_NONE, ACT_CLEAR, ACT_TOGGLE};
    logic              wexp [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    int                sels [5] = '{1, 2, 3, 4, 15};
    int                compares = 0, miscompares = 0, seed, diff;

    always #25 clock_in = ~clock_in;

    ftc_core u_dut (
        .clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .fast_clk_in(fast_clk),
        .pll_locked_in(pll_locked), .pll_enable_out(pll_en), .low_speed_select_out(low_speed_select),
        .service_ack_in(service_ack_in), .irq_out(irq_out), .waveform_output_out(wave),
        .top_out(), .bottom_out()
    );
    ftc_pll_model #(.HALF_NS(HALF_NS)) u_pll (
        .clock_in(clock_in), .rst_in(rst_in), .pll_enable_in(pll_en),
        .low_speed_select_in(low_speed_select), .fast_clk_out(fast_clk), .pll_locked_out(pll_locked)
    );

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic summarize;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask : wr_reg
    // Polls and tolerant reads skip the queue
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m,
                          input logic note);
        @(posedge clock_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        if (note) begin
            exp_q.push_back(e);
            msk_q.push_back(m);
        end
        @(posedge clock_in);
        rd_in <= 1'b0;
        @(posedge clock_in);
        #1;
    endtask : rd_reg
    task automatic run(input logic [7:0] sel, input int n);
        wr_reg(ADDR_CTRL_B, sel);
        repeat (n) @(posedge clock_in);
        wr_reg(ADDR_CTRL_B, 8'h00);
        repeat (8) @(posedge clock_in);
    endtask : run
    task automatic near(input string what, input int exp);
        rd_reg(ADDR_COUNT, 8'h00, 8'h00, 1'b0);
        diff = int'(last_rd) - exp;
        check(what, 8'(diff <= 4 && diff >= -4), 8'h01);
    endtask : near

    always @(posedge clock_in) begin
        if (rd_d) begin
            last_rd = rdata_out;
            if (exp_q.size() > 0) check("rdata", rdata_out & msk_q.pop_front(), exp_q.pop_front());
        end
        rd_d = rd_in;
    end

    initial begin
        repeat (30000) @(posedge clock_in);
        miscompares++;
        summarize();
    end

    initial begin
        rst_in = 1'b1;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 4'h0;
        wdata_in = 8'h00;
        service_ack_in = 4'h0;
        seed = $urandom(18064);
        repeat (6) @(posedge clock_in);
        rst_in <= 1'b0;
        rd_reg(ADDR_CMP_A, CMP_RESET[7:0], 8'hFF, 1'b1);
        rd_reg(ADDR_COUNT, 8'h00, 8'hFF, 1'b1);
        for (int a = 13; a < 16; a++) rd_reg(4'(a), 8'h00, 8'hFF, 1'b1);
        // Stopped counter still takes a ten-bit write
        v = 8'($urandom);
        wr_reg(ADDR_HIGH, 8'h02);
        wr_reg(ADDR_COUNT, v);
        repeat (6) @(posedge clock_in);
        wr_reg(ADDR_HIGH, 8'h00);
        rd_reg(ADDR_COUNT, v, 8'hFF, 1'b1);
        rd_reg(ADDR_HIGH, 8'h02, 8'h03, 1'b1);
        wr_reg(ADDR_HIGH, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            wr_reg(ADDR_CMP_A + 4'(i), v);
            rd_reg(ADDR_CMP_A + 4'(i), v, 8'hFF, 1'b1);
        end
        wr_reg(ADDR_CTRL_A, 8'h01);
        v = 8'($urandom);
        wr_reg(ADDR_CMP_A, v);
        rd_reg(ADDR_CMP_A, v, 8'hFF, 1'b1);
        wr_reg(ADDR_CTRL_A, 8'h00);
        // Matches, flags and requests, top from the top register
        wr_reg(ADDR_CMP_T, 8'h40);
        wr_reg(ADDR_CMP_A, 8'h05);
        wr_reg(ADDR_CMP_B, 8'h38);
        wr_reg(ADDR_CMP_D, 8'h10);
        wr_reg(ADDR_FLAGS, 8'h0F);
        wr_reg(ADDR_MASK, 8'h0F);
        wr_reg(ADDR_COUNT, 8'h00);
        run(8'h01, 40);
        rd_reg(ADDR_FLAGS, 8'h09, 8'h0F, 1'b1);
        check("irq", 8'(irq_out), 8'h09);
        wr_reg(ADDR_FLAGS, 8'h01);
        @(posedge clock_in);
        service_ack_in <= 4'h8;
        @(posedge clock_in);
        service_ack_in <= 4'h0;
        repeat (6) @(posedge clock_in);
        rd_reg(ADDR_FLAGS, 8'h00, 8'h0F, 1'b1);
        check("irq", 8'(irq_out), 8'h00);
        run(8'h01, 40);
        rd_reg(ADDR_FLAGS, 8'h04, 8'h04, 1'b1);
        rd_reg(ADDR_COUNT, 8'h00, 8'h00, 1'b0);
        check("wrap", 8'(last_rd <= 8'h40), 8'h01);
        // Count write equal to a compare value hides that match
        wr_reg(ADDR_FLAGS, 8'h0F);
        wr_reg(ADDR_COUNT, 8'h05);
        run(8'h01, 12);
        rd_reg(ADDR_FLAGS, 8'h00, 8'h01, 1'b1);
        wr_reg(ADDR_MASK, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr_reg(ADDR_CTRL_A, 8'((acts[i] << CA_ACT_A) | (1 << CA_FORCE_A)));
            repeat (6) @(posedge clock_in);
            check("wave", 8'(wave[0]), 8'(wexp[i]));
        end
        rd_reg(ADDR_FLAGS, 8'h00, 8'h01, 1'b1);
        wr_reg(ADDR_CTRL_D, 8'(MODE_MAX_TOP));
        for (int i = 0; i < 5; i++) begin
            wr_reg(ADDR_COUNT, 8'h00);
            run(8'(8'h80 | sels[i]), 64);
            near("prescale", 64 >> (sels[i] - 1));
        end
        wr_reg(ADDR_PLL, 8'h04);
        repeat (2000) @(posedge clock_in);
        for (int i = 0; i < 200 && !last_rd[PL_LOCK]; i++) rd_reg(ADDR_PLL, 8'h00, 8'h00, 1'b0);
        check("lock", 8'(last_rd[PL_LOCK]), 8'h01);
        for (int s = 0; s < 2; s++) begin
            wr_reg(ADDR_PLL, 8'(8'h05 | (s << PL_LSM)));
            wr_reg(ADDR_COUNT, 8'h00);
            run(8'h81, 80);
            near("async", (80 * 25) / (HALF_NS << s));
        end
        summarize();
    end
endmodule : tb_top
`default_nettype wire
